// [include/ocld_pkg.sv]
package ocld_pkg;

	// clock and time figures
	localparam int CLK_PERIOD_NS = 4;
	localparam int SC_BLANK_NS = 1000;
	localparam int FIRST_BLANK_NS = 2000;
	localparam int FAULT_INDICATOR_PIN_RUN_NS = 57000;
	localparam int FAULT_INDICATOR_PIN_WAIT_NS = 32000;
	localparam int SC_BLANK_CYC =
		(SC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIRST_BLANK_CYC =
		(FIRST_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_INDICATOR_PIN_RUN_CYC =
		(FAULT_INDICATOR_PIN_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_INDICATOR_PIN_WAIT_CYC =
		(FAULT_INDICATOR_PIN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// widths
	localparam int CNT_W = 16;
	localparam int BLANK_W = 10;
	localparam int IRQ_W = 3;
	localparam int CTRL_W = 2;

	// register byte offsets
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;

	// control fields and reset values
	localparam int CTRL_SC_BLANK_BIT = 0;
	localparam int CTRL_AUTO_REC_BIT = 1;
	localparam int CTRL_OC_CLEAR_BIT = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

	// interrupt event positions
	localparam int IRQ_OC_TRIP = 0;
	localparam int IRQ_FAULT_INDICATOR_PIN_FAIL = 1;
	localparam int IRQ_FAULT_INDICATOR_PIN_DONE = 2;

	// detector masks: bit3 over-current, bits 5:4 open-load
	localparam logic [5:0] DET_CHECK_FULL = 6'h3F;
	localparam logic [5:0] DET_CHECK_HALF = 6'h0F;

	// diagnosis sequencer, gray along wait-fault_indicator_pin-run
	typedef enum logic [1:0] {
		ST_WAIT = 2'h0,
		ST_FAULT_INDICATOR_PIN = 2'h1,
		ST_RUN = 2'h3,
		ST_FAIL = 2'h2
	} ocld_fsm_e;

	// pin inputs, carried through the synchronisers
	typedef struct packed {
		logic en;
		logic active_low_enable;
		logic [3:0] oc;
		logic [4:0] oth;
		logic charge_pump_ok;
		logic half_bridge;
		logic por_low;
		logic [1:0] uv_hyst;
		logic fault_pin;
	} ocld_pins_s;

endpackage

// [src/ocld_top.sv]
`timescale 1ns/1ns
`default_nettype none
module ocld_top import ocld_pkg::*; #(
	parameter int FAULT_INDICATOR_PIN_RUN_CYCLES = FAULT_INDICATOR_PIN_RUN_CYC,
	parameter int FAULT_INDICATOR_PIN_WAIT_CYCLES = FAULT_INDICATOR_PIN_WAIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic en_pin,
	input wire logic active_low_enable,
	input wire logic [3:0] oc_det,
	input wire logic [4:0] other_det,
	input wire logic charge_pump_ok,
	input wire logic half_bridge_mode,
	input wire logic por_low,
	input wire logic [1:0] uv_hyst,
	input wire logic fault_indicator_pin_i,
	output logic fault_indicator_pin_o,
	output logic fault_indicator_pin_oe,
	output logic out_off,
	output logic thr_sel,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq
);

	localparam logic [CNT_W-1:0] RUN_LAST = CNT_W'(FAULT_INDICATOR_PIN_RUN_CYCLES - 1);
	localparam logic [CNT_W-1:0] WAIT_DONE = CNT_W'(FAULT_INDICATOR_PIN_WAIT_CYCLES);
	localparam logic [BLANK_W-1:0] SC_LIM = BLANK_W'(SC_BLANK_CYC);
	localparam logic [BLANK_W-1:0] FIRST_LIM = BLANK_W'(FIRST_BLANK_CYC);

	typedef struct packed {
		ocld_pins_s s1;
		ocld_pins_s s2;
		logic en_p;
		logic enb_p;
		logic act_p;
		ocld_fsm_e fsm;
		logic [CNT_W-1:0] wait_cnt;
		logic [CNT_W-1:0] run_cnt;
		logic [5:0] seen;
		logic hyst_seen;
		logic fault_indicator_pin_fail;
		logic [BLANK_W-1:0] blank_cnt;
		logic latched;
		logic [3:0] first;
		logic fault_low;
		logic [CTRL_W-1:0] ctrl;
		logic [IRQ_W-1:0] istat;
		logic [IRQ_W-1:0] imask;
		logic out_off;
		logic thr_sel;
		logic fault_oe;
		logic irq;
		logic [31:0] rdata;
	} ocld_state_s;

	ocld_state_s q, d;
	logic [1:0] rst_sync_q;
	logic rst_n_s;
	ocld_pins_s pins_in;
	logic enabled, restart_pulse, fault_clr_edge, disable_edge;
	logic oc_any, latch_mode, ser_clr, oc_cond, trip;
	logic [5:0] det, chk;
	logic [BLANK_W-1:0] blank_lim;
	logic [IRQ_W-1:0] ev;

	function automatic logic edge_up(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_s = rst_sync_q[1];

	// pins gathered for the synchroniser
	assign pins_in = '{en: en_pin, active_low_enable: active_low_enable,
		oc: oc_det, oth: other_det, charge_pump_ok: charge_pump_ok,
		half_bridge: half_bridge_mode, por_low: por_low,
		uv_hyst: uv_hyst, fault_pin: fault_indicator_pin_i};

	// enable decode and edges on synchronised pins
	assign enabled = q.s2.en & ~q.s2.active_low_enable;
	assign restart_pulse = edge_up(q.en_p, q.s2.en) |
		edge_up(q.s2.active_low_enable, q.enb_p);
	assign fault_clr_edge = edge_up(q.s2.en, q.en_p) |
		edge_up(q.enb_p, q.s2.active_low_enable);
	assign disable_edge = q.act_p & ~enabled;

	// detector vector, oc at bit 3; charge pump kept out
	assign oc_any = |q.s2.oc;
	assign det = {q.s2.oth[4:3], oc_any, q.s2.oth[2:0]};
	assign chk = q.s2.half_bridge ? DET_CHECK_HALF : DET_CHECK_FULL;

	// over-current qualification
	assign latch_mode = ~q.ctrl[CTRL_AUTO_REC_BIT] | q.s2.half_bridge;
	assign blank_lim = q.ctrl[CTRL_SC_BLANK_BIT] ? SC_LIM : FIRST_LIM;
	assign ser_clr = wr && (addr == ADDR_CTRL) &&
		wdata[CTRL_OC_CLEAR_BIT];
	assign oc_cond = (q.fsm == ST_RUN) & enabled & oc_any &
		~q.latched;
	assign trip = oc_cond & (q.blank_cnt == blank_lim - 1'b1);

	// next state
	always_comb begin
		d = q;
		ev = '0;
		d.s1 = pins_in;
		d.s2 = q.s1;
		d.en_p = q.s2.en;
		d.enb_p = q.s2.active_low_enable;
		d.act_p = enabled;
		// blanking counter runs while excess current persists
		if (oc_cond) begin
			if (q.blank_cnt != blank_lim) begin
				d.blank_cnt = q.blank_cnt + 1'b1;
			end
		end else begin
			d.blank_cnt = '0;
		end
		// latch and first flag; a trip wins over a clear
		if (trip & latch_mode) begin
			d.latched = 1'b1;
			d.first = q.s2.oc & (~q.s2.oc + 4'h1);
		end else if (restart_pulse | ser_clr) begin
			d.latched = 1'b0;
			d.first = 4'h0;
		end
		if (trip) begin
			ev[IRQ_OC_TRIP] = 1'b1;
		end
		// elapsed time since reset release or disable, saturating
		if (disable_edge) begin
			d.wait_cnt = '0;
		end else if (q.wait_cnt != WAIT_DONE) begin
			d.wait_cnt = q.wait_cnt + 1'b1;
		end
		// diagnosis sequencer
		unique case (q.fsm)
			ST_WAIT: begin
				if (q.wait_cnt == WAIT_DONE && det == 6'h00 &&
					q.s2.charge_pump_ok && !q.s2.por_low) begin
					d.fsm = ST_FAULT_INDICATOR_PIN;
					d.run_cnt = '0;
					d.seen = 6'h00;
					d.hyst_seen = 1'b0;
					d.fault_indicator_pin_fail = 1'b0;
				end
			end
			ST_FAULT_INDICATOR_PIN: begin
				d.seen = q.seen | det;
				d.hyst_seen = q.hyst_seen | (|q.s2.uv_hyst);
				if (q.s2.por_low) begin
					d.fsm = ST_WAIT;
				end else if (q.run_cnt == RUN_LAST) begin
					ev[IRQ_FAULT_INDICATOR_PIN_DONE] = 1'b1;
					if (d.hyst_seen || (chk & ~d.seen) != 6'h00) begin
						d.fsm = ST_FAIL;
						d.fault_indicator_pin_fail = 1'b1;
						ev[IRQ_FAULT_INDICATOR_PIN_FAIL] = 1'b1;
					end else begin
						d.fsm = ST_RUN;
					end
				end else begin
					d.run_cnt = q.run_cnt + 1'b1;
				end
			end
			ST_RUN: begin
			end
			ST_FAIL: begin
			end
		endcase
		if (disable_edge) begin
			d.fsm = ST_WAIT;
		end
		// fault pin latch; a new fault wins over a clear
		if (trip | ev[IRQ_FAULT_INDICATOR_PIN_FAIL]) begin
			d.fault_low = 1'b1;
		end else if (fault_clr_edge | ser_clr) begin
			d.fault_low = 1'b0;
		end
		// registers
		if (wr && addr == ADDR_CTRL) begin
			d.ctrl = wdata[CTRL_W-1:0];
		end
		if (wr && addr == ADDR_IRQ_MASK) begin
			d.imask = wdata[IRQ_W-1:0];
		end
		if (wr && addr == ADDR_IRQ_STAT) begin
			d.istat = q.istat & ~wdata[IRQ_W-1:0];
		end
		d.istat = d.istat | ev;
		d.rdata = 32'h0;
		if (rd) begin
			unique case (addr)
				ADDR_CTRL: d.rdata = {30'h0, q.ctrl};
				ADDR_STATUS: d.rdata = {22'h0, q.fsm, ~q.s2.fault_pin,
					q.fsm == ST_FAULT_INDICATOR_PIN, q.fault_indicator_pin_fail, q.out_off, q.first};
				ADDR_IRQ_STAT: d.rdata = {29'h0, q.istat};
				ADDR_IRQ_MASK: d.rdata = {29'h0, q.imask};
				default: d.rdata = 32'h0;
			endcase
		end
		// outputs
		d.thr_sel = (d.fsm == ST_FAULT_INDICATOR_PIN);
		d.out_off = d.latched | ~enabled | (d.fsm != ST_RUN) |
			(oc_cond & ~latch_mode & d.blank_cnt == blank_lim);
		d.fault_oe = d.fault_low | d.fault_indicator_pin_fail;
		d.irq = |(d.istat & d.imask);
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			q <= '0;
			q.fsm <= ST_WAIT;
			q.ctrl <= CTRL_RESET;
			q.imask <= IRQ_MASK_RESET;
			q.out_off <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign fault_indicator_pin_o = 1'b0;
	assign fault_indicator_pin_oe = q.fault_oe;
	assign out_off = q.out_off;
	assign thr_sel = q.thr_sel;
	assign rdata = q.rdata;
	assign irq = q.irq;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n_s);

	property p_blank;
		$rose(q.latched) |-> $past(q.blank_cnt) == $past(blank_lim) - 1'b1;
	endproperty
	a_blank: assert property (p_blank)
		else $error("shutdown latched before blanking elapsed");

	property p_restart;
		restart_pulse && !trip |=> !q.latched;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart pulse did not clear latch");

	property p_sc_blank;
		$rose(q.latched) && $past(q.ctrl[CTRL_SC_BLANK_BIT]) |->
			$past(q.blank_cnt) == SC_LIM - 1'b1;
	endproperty
	a_sc_blank: assert property (p_sc_blank)
		else $error("short-circuit blanking not applied");

	property p_ser_clr;
		ser_clr && !trip |=> !q.latched ##1 (!q.out_off || !enabled ||
			q.fsm != ST_RUN || oc_any || q.latched);
	endproperty
	a_ser_clr: assert property (p_ser_clr)
		else $error("serial clear did not release shutdown");

	property p_fault_clr;
		fault_clr_edge && !trip && !ev[IRQ_FAULT_INDICATOR_PIN_FAIL] |=> !q.fault_low;
	endproperty
	a_fault_clr: assert property (p_fault_clr)
		else $error("enable edge did not clear fault pin");

	property p_thr;
		##1 (q.thr_sel == (q.fsm == ST_FAULT_INDICATOR_PIN));
	endproperty
	a_thr: assert property (p_thr)
		else $error("threshold select out of step with diagnosis");

	property p_wait;
		q.fsm == ST_WAIT && (q.wait_cnt != WAIT_DONE || det != 6'h00)
			|=> q.fsm != ST_FAULT_INDICATOR_PIN;
	endproperty
	a_wait: assert property (p_wait)
		else $error("diagnosis started too early");

	property p_fail_pin;
		$rose(q.fault_indicator_pin_fail) |-> q.fault_oe && q.fsm == ST_FAIL;
	endproperty
	a_fail_pin: assert property (p_fail_pin)
		else $error("failed diagnosis without fault pin");

	property p_disable;
		disable_edge |=> q.fsm == ST_WAIT && q.wait_cnt == '0;
	endproperty
	a_disable: assert property (p_disable)
		else $error("disable did not restart diagnosis");

	property p_por;
		q.s2.por_low && q.fsm == ST_FAULT_INDICATOR_PIN |=> q.fsm == ST_WAIT;
	endproperty
	a_por: assert property (p_por)
		else $error("diagnosis ran below reset level");

	property p_no_oc_fault_indicator_pin;
		q.fsm == ST_FAULT_INDICATOR_PIN |=> !$rose(q.latched);
	endproperty
	a_no_oc_fault_indicator_pin: assert property (p_no_oc_fault_indicator_pin)
		else $error("over-current tripped during diagnosis");

	property p_first;
		q.latched && !restart_pulse && !ser_clr |=> $stable(q.first);
	endproperty
	a_first: assert property (p_first)
		else $error("first fault flag changed while latched");

endmodule
`default_nettype wire

// [verification/ocld_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ocld_host_model (
	input wire logic ref_clk,
	output logic en_pin,
	output logic active_low_enable,
	output logic [3:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd
);
	// channel enabled, bus idle
	initial begin
		en_pin = 1'b1;
		active_low_enable = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one-cycle strobe, fields held until the taking edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		wdata <= ~d; // stale data not left on the bus
	endtask

	// disable pulse on one enable pin, then enable again
	task automatic restart(input logic low_pin, input int len);
		@(posedge ref_clk);
		if (low_pin) begin
			active_low_enable <= 1'b1;
		end else begin
			en_pin <= 1'b0;
		end
		repeat (len) @(posedge ref_clk);
		active_low_enable <= 1'b0;
		en_pin <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [verification/tb_ocld_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_ocld_top;
	import ocld_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] oc_drv = 4'h0;
	logic [1:0] uv_hyst = 2'h0;
	logic half_bridge_mode = 1'b0;
	logic cp_ok = 1'b1;
	logic por_drv = 1'b0;
	logic rd_p1 = 1'b0;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 32'hA3C535F9;
	int n;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	wire en_pin;
	wire active_low_enable;
	wire wr;
	wire rd;
	wire [3:0] addr_w;
	wire [31:0] wdata;
	wire [31:0] rdata;
	wire fault_oe;
	wire fault_o;
	wire out_off;
	wire thr_sel;
	wire irq;
	wire [3:0] oc_det;
	wire [4:0] other_det;

	// comparators read detected under diagnosis thresholds
	assign oc_det = thr_sel ? 4'hF : oc_drv;
	assign other_det = thr_sel ? (half_bridge_mode ? 5'h07 : 5'h1F) : 5'h00;

	always #2 ref_clk = ~ref_clk;

	ocld_host_model host_u (.ref_clk(ref_clk), .en_pin(en_pin),
		.active_low_enable(active_low_enable), .addr(addr_w),
		.wdata(wdata), .wr(wr), .rd(rd));

	ocld_top #(.FAULT_INDICATOR_PIN_RUN_CYCLES(20), .FAULT_INDICATOR_PIN_WAIT_CYCLES(10)) dut_u (
		.ref_clk(ref_clk), .rstn(rstn), .en_pin(en_pin),
		.active_low_enable(active_low_enable), .oc_det(oc_det),
		.other_det(other_det), .charge_pump_ok(cp_ok),
		.half_bridge_mode(half_bridge_mode), .por_low(por_drv),
		.uv_hyst(uv_hyst), .fault_indicator_pin_i(!fault_oe),
		.fault_indicator_pin_o(fault_o), .fault_indicator_pin_oe(fault_oe),
		.out_off(out_off), .thr_sel(thr_sel), .addr(addr_w),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			failures++;
		end
	endtask

	task automatic summarize();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// read with the expected word noted for the monitor
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		host_u.bus(1'b0, a, 32'h0);
	endtask

	// settled-output wait, counting cycles until thr_sel reaches v
	task automatic span(input logic v, output int k);
		k = 0;
		while (thr_sel !== v && k < 300) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
	endtask

	// burst under the blanking time, then a trip
	task automatic trip();
		n = 200 + ($unsigned($random(seed)) % 40);
		oc_drv <= 4'h2;
		repeat (n) @(posedge ref_clk);
		oc_drv <= 4'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		check(out_off, 1'b0);
		oc_drv <= 4'h2;
		repeat (245) @(posedge ref_clk);
		#1;
		check(out_off, 1'b0);
		oc_drv <= 4'h6;
		repeat (15) @(posedge ref_clk);
		#1;
		check({out_off, fault_oe, fault_o}, 3'h6);
	endtask

	// read data stand in the cycle after the strobe
	always @(posedge ref_clk) begin
		rd_p1 <= rd;
		if (rd_p1 && exp_q.size() > 0) begin
			check(rdata & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end

	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd_chk(ADDR_CTRL, 32'h1, 32'h7);
		rd_chk(ADDR_IRQ_MASK, 32'h0, 32'h7);
		rd_chk(4'h2, 32'h0, 32'hFFFFFFFF);
		span(1'b1, n);
		span(1'b0, n);
		check(n, 20);
		repeat (3) @(posedge ref_clk);
		#1;
		check(out_off, 1'b0);
		rd_chk(ADDR_STATUS, 32'h300, 32'h3F0);
		host_u.bus(1'b1, ADDR_IRQ_MASK, {$random(seed)} & 32'hFFF8 | 32'h1);
		trip();
		rd_chk(ADDR_STATUS, 32'h92, 32'hFF);
		oc_drv <= 4'h0;
		repeat (100) @(posedge ref_clk);
		#1;
		check({out_off, fault_oe, irq}, 3'h7);
		host_u.bus(1'b1, ADDR_IRQ_STAT, 32'h7);
		repeat (3) @(posedge ref_clk);
		#1;
		check(irq, 1'b0);
		host_u.bus(1'b1, ADDR_CTRL, 32'h5);
		repeat (4) @(posedge ref_clk);
		#1;
		check({out_off, fault_oe}, 2'h0);
		// auto recovery with first blanking: no trip before 500 cycles
		host_u.bus(1'b1, ADDR_CTRL, 32'h2);
		oc_drv <= 4'h1;
		repeat (300) @(posedge ref_clk);
		#1;
		check(out_off, 1'b0);
		repeat (220) @(posedge ref_clk);
		#1;
		check(out_off, 1'b1);
		oc_drv <= 4'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		check(out_off, 1'b0);
		host_u.bus(1'b1, ADDR_CTRL, 32'h5);
		for (int i = 0; i < 2; i++) begin
			half_bridge_mode <= i[0];
			trip();
			oc_drv <= 4'h0;
			host_u.restart(i[0], 3);
			span(1'b1, n);
			check(n >= 7, 1'b1);
			span(1'b0, n);
			repeat (3) @(posedge ref_clk);
			#1;
			check({out_off, fault_oe}, 2'h0);
			rd_chk(ADDR_STATUS, 32'h300, 32'h3F0);
		end
		// charge pump gates the start, low supply stops a running one
		cp_ok <= 1'b0;
		host_u.restart(1'b0, 3);
		repeat (30) @(posedge ref_clk);
		#1;
		check(thr_sel, 1'b0);
		cp_ok <= 1'b1;
		span(1'b1, n);
		check(n, 3);
		por_drv <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		check(thr_sel, 1'b0);
		por_drv <= 1'b0;
		span(1'b1, n);
		check(n, 3);
		span(1'b0, n);
		uv_hyst <= 2'h1;
		host_u.restart(1'b0, 3);
		span(1'b1, n);
		span(1'b0, n);
		repeat (3) @(posedge ref_clk);
		#1;
		check(fault_oe, 1'b1);
		rd_chk(ADDR_STATUS, 32'h2A0, 32'h3A0);
		repeat (4) @(posedge ref_clk);
		summarize();
	end
endmodule
`default_nettype wire
